// ===== hdl/rsif_pkg.sv
package rsif_pkg;
  // ***************************************************************
  // bus and register map
  // ***************************************************************
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam logic [7:0]  OFS_WDOG_CTRL = 8'h00;
  localparam logic [7:0]  OFS_IRQ_EN    = 8'h04;
  localparam logic [7:0]  OFS_EXT_IRQ_EN = 8'h08;
  localparam logic [7:0]  OFS_TMR_CTRL  = 8'h0C;
  localparam logic [7:0]  OFS_TMR2_FLAG = 8'h10;
  localparam logic [7:0]  OFS_STACK_PTR = 8'h14;
  localparam logic [7:0]  OFS_PORT_OUT  = 8'h18;
  // ***************************************************************
  // watchdog control fields and source-dependent reset
  // ***************************************************************
  localparam int          WDC_CLR       = 0;
  localparam int          WDC_RSTEN     = 1;
  localparam int          WDC_RSTF      = 2;
  localparam int          WDC_TOF       = 3;
  localparam int          WDC_SEL_LO    = 4;
  localparam int          WDC_SEL_HI    = 5;
  localparam int          WDC_POR       = 6;
  localparam logic [7:0]  WDC_RW_MASK   = 8'h7E;
  localparam logic [7:0]  WDC_EXT_KEEP  = 8'h56;
  localparam logic [7:0]  WDC_EXT_SET   = 8'h00;
  localparam logic [7:0]  WDC_WD_KEEP   = 8'h52;
  localparam logic [7:0]  WDC_WD_SET    = 8'h04;
  localparam logic [7:0]  WDC_POR_VAL   = 8'h40;
  // ***************************************************************
  // timer control, timer 2 flag and interrupt enable fields
  // ***************************************************************
  localparam int          TC_TRIG0      = 0;
  localparam int          TC_EXT0F      = 1;
  localparam int          TC_TRIG1      = 2;
  localparam int          TC_EXT1F      = 3;
  localparam int          TC_T0F        = 5;
  localparam int          TC_T1F        = 7;
  localparam logic [7:0]  TC_MASK       = 8'hAF;
  localparam int          T2_CAPF       = 6;
  localparam int          T2_OVF        = 7;
  localparam logic [7:0]  T2_MASK       = 8'hC0;
  localparam int          IE_GLOBAL     = 7;
  localparam logic [7:0]  IE_MASK       = 8'hBF;
  localparam int          EIE_W         = 5;
  localparam int          EIE_WDOG      = 4;
  // ***************************************************************
  // interrupt sources and service acknowledge ids
  // ***************************************************************
  localparam int          N_SRC         = 11;
  localparam int          N_AUX         = 4;
  localparam int          ACK_ID_W      = 4;
  localparam logic [3:0]  ACK_EXT0      = 4'h0;
  localparam logic [3:0]  ACK_T0        = 4'h1;
  localparam logic [3:0]  ACK_EXT1      = 4'h2;
  localparam logic [3:0]  ACK_T1        = 4'h3;
  // ***************************************************************
  // reset values and timing
  // ***************************************************************
  localparam int          PC_W          = 16;
  localparam logic [15:0] PC_RST        = 16'h0000;
  localparam logic [7:0]  SP_RST        = 8'h07;
  localparam logic [7:0]  PORT_RST      = 8'hFF;
  localparam int          N_PORT        = 4;
  localparam logic [1:0]  MC_LAST       = 2'h3;
  localparam int          MC_CLKS       = 4;
  localparam int          WD_DLY_CLKS   = 512;
  localparam int          WD_HOLD_MC    = 2;
  localparam int          EXT_HOLD_MC   = 2;
  localparam logic [9:0]  WD_DLY_LAST   = 10'(WD_DLY_CLKS - 1);
  localparam logic [3:0]  WD_HOLD_LAST  = 4'(WD_HOLD_MC * MC_CLKS - 1);
  localparam logic [1:0]  EXT_HOLD_INIT = 2'(EXT_HOLD_MC);
  localparam int          WD_SEL_STEP   = 3;

  typedef enum logic [1:0] {
    WD_RUN   = 2'b00,
    WD_ARMED = 2'b01,
    WD_RESET = 2'b10
  } rsif_wd_e;
endpackage : rsif_pkg

// ===== hdl/rsif_ext_sampler.sv
`timescale 1ns/1ps
module rsif_ext_sampler
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic smp_i,
  input  wire logic pin_i,
  input  wire logic edge_sel_i,
  output logic      set_o
);
  import rsif_pkg::*;

  typedef struct packed {
    logic last;
  } rsif_smp_s;

  rsif_smp_s st_reg;
  rsif_smp_s st_next;

  // ***************************************************************
  // once per machine cycle sampling
  // ***************************************************************
  always_comb
  begin
    st_next = st_reg;
    set_o   = 1'b0;
    if (smp_i)
    begin
      // edge needs one high sample then one low one
      set_o       = edge_sel_i ? (st_reg.last & ~pin_i) : ~pin_i;
      st_next.last = pin_i;
    end
    // starts high so a pin low at reset counts as an edge on the first sample
    if (rst_i)
    begin
      st_next.last = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    st_reg <= st_next;
  end
endmodule : rsif_ext_sampler

// ===== hdl/rsif_top.sv
`timescale 1ns/1ps
module rsif_top
#(
  parameter int WD_BASE_BITS = 17
)
(
  input  wire logic                            MCLK_I,
  input  wire logic                            RST_I,
  input  wire logic                            PSEL_I,
  input  wire logic                            PENABLE_I,
  input  wire logic                            PWRITE_I,
  input  wire logic [rsif_pkg::ADDR_W-1:0]     PADDR_I,
  input  wire logic [rsif_pkg::DATA_W-1:0]     PWDATA_I,
  output logic      [rsif_pkg::DATA_W-1:0]     PRDATA_O,
  output logic                                 PREADY_O,
  output logic                                 PSLVERR_O,
  input  wire logic                            EXT_RST_I,
  input  wire logic                            EXT_IRQ0_PIN_I,
  input  wire logic                            EXT_IRQ1_PIN_I,
  input  wire logic                            TMR0_OVF_I,
  input  wire logic                            TMR1_OVF_I,
  input  wire logic                            TMR2_OVF_I,
  input  wire logic                            TMR2_CAPRLD_I,
  input  wire logic                            SERIAL_IRQ_I,
  input  wire logic [rsif_pkg::N_AUX-1:0]      AUX_IRQ_I,
  input  wire logic                            IRQ_ACK_I,
  input  wire logic [rsif_pkg::ACK_ID_W-1:0]   IRQ_ACK_ID_I,
  input  wire logic [rsif_pkg::PC_W-1:0]       CORE_PC_I,
  output logic                                 SYS_RST_O,
  output logic      [rsif_pkg::PC_W-1:0]       PC_O,
  output logic      [7:0]                      STACK_PTR_O,
  output logic      [8*rsif_pkg::N_PORT-1:0]   PORT_OUT_O,
  output logic      [rsif_pkg::N_SRC-1:0]      IRQ_REQ_O
);
  import rsif_pkg::*;

  localparam int WDW = WD_BASE_BITS + 3 * WD_SEL_STEP + 1;

  typedef struct packed {
    logic [1:0]            mc_cnt;
    logic [1:0]            ext_hold;
    rsif_wd_e              wd_state;
    logic [WDW-1:0]        wd_cnt;
    logic [9:0]            wd_dly;
    logic [3:0]            wd_hold;
    logic [7:0]            wdc;
    logic [7:0]            ie;
    logic [EIE_W-1:0]      extended_irq_enable_reg;
    logic [7:0]            tc;
    logic [7:0]            t2;
    logic [7:0]            sp;
    logic [8*N_PORT-1:0]   port;
    logic [PC_W-1:0]       pc;
    logic [DATA_W-1:0]     prdata;
    logic                  pslverr;
  } rsif_state_s;

  rsif_state_s st_reg;
  rsif_state_s st_next;

  logic                  mc_strobe;
  logic                  ext_act;
  logic                  wd_act;
  logic                  ext0_set;
  logic                  ext1_set;
  logic [N_SRC-1:0]      flags;
  logic [N_SRC-1:0]      enables;

  assign mc_strobe = (st_reg.mc_cnt == MC_LAST);
  assign ext_act   = (st_reg.ext_hold != 2'h0);
  assign wd_act    = (st_reg.wd_state == WD_RESET);

  // ***************************************************************
  // external interrupt pin samplers
  // ***************************************************************
  rsif_ext_sampler u_ext0 (
    .clk_i      (MCLK_I),
    .rst_i      (SYS_RST_O),
    .smp_i      (mc_strobe),
    .pin_i      (EXT_IRQ0_PIN_I),
    .edge_sel_i (st_reg.tc[TC_TRIG0]),
    .set_o      (ext0_set)
  );

  rsif_ext_sampler u_ext1 (
    .clk_i      (MCLK_I),
    .rst_i      (SYS_RST_O),
    .smp_i      (mc_strobe),
    .pin_i      (EXT_IRQ1_PIN_I),
    .edge_sel_i (st_reg.tc[TC_TRIG1]),
    .set_o      (ext1_set)
  );

  // ***************************************************************
  // timeout compare
  // ***************************************************************
  function automatic logic wd_hit(input logic [WDW-1:0] cnt, input logic [1:0] sel);
    logic [WDW-1:0] mask;
    mask = WDW'((64'h1 << (WD_BASE_BITS + WD_SEL_STEP * int'(sel))) - 64'h1);
    return ((cnt & mask) == mask);
  endfunction : wd_hit

  // ***************************************************************
  // interrupt requests
  // ***************************************************************
  always_comb
  begin
    // timer 2 shares one source slot
    flags   = {st_reg.wdc[WDC_TOF], AUX_IRQ_I, st_reg.t2[T2_OVF] | st_reg.t2[T2_CAPF],
               SERIAL_IRQ_I, st_reg.tc[TC_T1F], st_reg.tc[TC_EXT1F], st_reg.tc[TC_T0F],
               st_reg.tc[TC_EXT0F]};
    // watchdog slot gated by extended bit 4
    enables = {st_reg.extended_irq_enable_reg, st_reg.ie[5:0]};
    // one enable per source, global gate over all
    IRQ_REQ_O = st_reg.ie[IE_GLOBAL] ? (flags & enables) : '0;
  end

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb
  begin
    logic            setup;
    logic            wr;
    logic            hit;
    logic            wd_clr;
    logic            tout;
    logic [7:0]      wb;
    logic            ack_e0;
    logic            ack_e1;
    logic            ack_t0;
    logic            ack_t1;
    setup   = PSEL_I & ~PENABLE_I;
    wr      = PSEL_I & PENABLE_I & PWRITE_I;
    wb      = PWDATA_I[7:0];
    hit     = 1'b0;
    wd_clr  = wr && (PADDR_I == OFS_WDOG_CTRL) && wb[WDC_CLR];
    tout    = wd_hit(st_reg.wd_cnt, st_reg.wdc[WDC_SEL_HI:WDC_SEL_LO]) && !wd_clr;
    ack_e0  = IRQ_ACK_I && (IRQ_ACK_ID_I == ACK_EXT0) && st_reg.tc[TC_TRIG0];
    ack_e1  = IRQ_ACK_I && (IRQ_ACK_ID_I == ACK_EXT1) && st_reg.tc[TC_TRIG1];
    ack_t0  = IRQ_ACK_I && (IRQ_ACK_ID_I == ACK_T0);
    ack_t1  = IRQ_ACK_I && (IRQ_ACK_ID_I == ACK_T1);
    st_next = st_reg;
    st_next.mc_cnt = st_reg.mc_cnt + 2'h1;

    // external reset pin, stretched two machine cycles
    if (mc_strobe)
    begin
      if (EXT_RST_I)
        st_next.ext_hold = EXT_HOLD_INIT;
      else if (ext_act)
        st_next.ext_hold = st_reg.ext_hold - 2'h1;
    end

    // free-running count, restart on software clear
    st_next.wd_cnt = wd_clr ? '0 : st_reg.wd_cnt + WDW'(1);

    unique case (st_reg.wd_state)
      WD_RUN:
      begin
        if (tout && st_reg.wdc[WDC_RSTEN])
        begin
          st_next.wd_state = WD_ARMED;
          st_next.wd_dly   = '0;
        end
      end
      WD_ARMED:
      begin
        st_next.wd_dly = st_reg.wd_dly + 10'h1;
        if (wd_clr || !st_reg.wdc[WDC_RSTEN])
          st_next.wd_state = WD_RUN;
        else if (st_reg.wd_dly == WD_DLY_LAST)
        begin
          // reset 512 clocks after the flag
          st_next.wd_state = WD_RESET;
          st_next.wd_hold  = WD_HOLD_LAST;
        end
      end
      WD_RESET:
      begin
        // held two machine cycles, released on a clock edge
        st_next.wd_hold = st_reg.wd_hold - 4'h1;
        st_next.wd_cnt  = '0;
        if (st_reg.wd_hold == 4'h0)
          st_next.wd_state = WD_RUN;
      end
      default:
        st_next.wd_state = WD_RUN;
    endcase

    // ***************************************************************
    // register writes; hardware set wins over software clear
    // ***************************************************************

    // every flag takes software writes
    if (wr && PADDR_I == OFS_WDOG_CTRL)
      st_next.wdc = (st_reg.wdc & ~WDC_RW_MASK) | (wb & WDC_RW_MASK);
    if (wr && PADDR_I == OFS_IRQ_EN)
      st_next.ie = wb & IE_MASK;
    if (wr && PADDR_I == OFS_EXT_IRQ_EN)
      st_next.extended_irq_enable_reg = wb[EIE_W-1:0];
    if (wr && PADDR_I == OFS_TMR_CTRL)
      st_next.tc = wb & TC_MASK;
    else
    begin
      // edge-mode flags drop on service entry
      // level-mode flags stay, a low pin sets them again
      if (ack_e0)
        st_next.tc[TC_EXT0F] = 1'b0;
      if (ack_e1)
        st_next.tc[TC_EXT1F] = 1'b0;
      // timer 0/1 flags clear on service
      if (ack_t0)
        st_next.tc[TC_T0F] = 1'b0;
      if (ack_t1)
        st_next.tc[TC_T1F] = 1'b0;
    end
    if (wr && PADDR_I == OFS_TMR2_FLAG)
      st_next.t2 = wb & T2_MASK;
    if (wr && PADDR_I == OFS_STACK_PTR)
      st_next.sp = wb;
    if (wr && PADDR_I == OFS_PORT_OUT)
      st_next.port = PWDATA_I;

    // hardware sets come last so they win over clears
    if (ext0_set)
      st_next.tc[TC_EXT0F] = 1'b1;
    if (ext1_set)
      st_next.tc[TC_EXT1F] = 1'b1;
    if (TMR0_OVF_I)
      st_next.tc[TC_T0F] = 1'b1;
    if (TMR1_OVF_I)
      st_next.tc[TC_T1F] = 1'b1;
    if (TMR2_OVF_I)
      st_next.t2[T2_OVF] = 1'b1;
    if (TMR2_CAPRLD_I)
      st_next.t2[T2_CAPF] = 1'b1;
    if (tout)
      st_next.wdc[WDC_TOF] = 1'b1;

    // ***************************************************************
    // read path, captured in the setup cycle
    // ***************************************************************
    // read data reflects state at setup; a flag set during access shows next read
    if (setup)
    begin
      st_next.prdata = '0;
      hit = 1'b1;
      unique case (PADDR_I)
        OFS_WDOG_CTRL:  st_next.prdata[7:0]       = st_reg.wdc;
        OFS_IRQ_EN:     st_next.prdata[7:0]       = st_reg.ie;
        OFS_EXT_IRQ_EN: st_next.prdata[EIE_W-1:0] = st_reg.extended_irq_enable_reg;
        OFS_TMR_CTRL:   st_next.prdata[7:0]       = st_reg.tc;
        OFS_TMR2_FLAG:  st_next.prdata[7:0]       = st_reg.t2;
        OFS_STACK_PTR:  st_next.prdata[7:0]       = st_reg.sp;
        OFS_PORT_OUT:   st_next.prdata            = st_reg.port;
        default:        hit = 1'b0;
      endcase
      st_next.pslverr = ~hit;
    end

    // program counter pinned while reset holds
    st_next.pc = SYS_RST_O ? PC_RST : CORE_PC_I;

    // ***************************************************************
    // reset state per source
    // ***************************************************************
    if (RST_I || wd_act || ext_act)
    begin
      // RAM untouched; the stack pointer reloads to 07h
      st_next.sp   = SP_RST;
      // all ports high
      st_next.port = {N_PORT{PORT_RST}};
      // interrupts off, most registers cleared
      st_next.ie   = '0;
      st_next.extended_irq_enable_reg  = '0;
      st_next.tc   = '0;
      st_next.t2   = '0;
      // source-dependent watchdog control
      if (wd_act)
        st_next.wdc = (st_reg.wdc & WDC_WD_KEEP) | WDC_WD_SET;
      else
        st_next.wdc = (st_reg.wdc & WDC_EXT_KEEP) | WDC_EXT_SET;
    end
    if (RST_I)
    begin
      // only power-on raises the indicator and drops the enable
      st_next.wdc      = WDC_POR_VAL;
      st_next.mc_cnt   = '0;
      st_next.ext_hold = '0;
      st_next.wd_state = WD_RUN;
      st_next.wd_cnt   = '0;
      st_next.wd_dly   = '0;
      st_next.wd_hold  = '0;
      st_next.pc       = PC_RST;
      st_next.prdata   = '0;
      st_next.pslverr  = 1'b0;
    end
  end

  always_ff @(posedge MCLK_I)
  begin
    st_reg <= st_next;
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  // any source resets the core; fetch resumes at 0000h after it
  assign SYS_RST_O   = RST_I | ext_act | wd_act;
  assign PC_O        = st_reg.pc;
  assign STACK_PTR_O = st_reg.sp;
  assign PORT_OUT_O  = st_reg.port;
  assign PRDATA_O    = st_reg.prdata;
  assign PSLVERR_O   = st_reg.pslverr & PSEL_I & PENABLE_I;
  assign PREADY_O    = 1'b1;
endmodule : rsif_top

// ===== test/rsif_monitor.sv
`timescale 1ns/1ps
// ************************************************
// port checker for the reset and request block
// ************************************************
module rsif_monitor
#(
  parameter int WD_BASE_BITS = 17
)
(
  input wire logic        MCLK_I,
  input wire logic        RST_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic        IRQ_ACK_I,
  input wire logic [3:0]  IRQ_ACK_ID_I,
  input wire logic        TMR0_OVF_I,
  input wire logic [15:0] CORE_PC_I,
  input wire logic        SYS_RST_O,
  input wire logic [15:0] PC_O,
  input wire logic [7:0]  STACK_PTR_O,
  input wire logic [31:0] PORT_OUT_O,
  input wire logic [10:0] IRQ_REQ_O
);
  logic apb_wr;
  assign apb_wr = PSEL_I & PENABLE_I & PWRITE_I;
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (RST_I);
  AST_PC_RST:
    assert property (SYS_RST_O |=> PC_O == 16'h0000) else $error("pc not zero in reset");
  AST_PC_RUN:
    assert property (!SYS_RST_O |=> PC_O == $past(CORE_PC_I)) else $error("pc not forwarded");
  AST_SP_RST:
    assert property (SYS_RST_O |=> STACK_PTR_O == 8'h07) else $error("stack pointer not 07");
  AST_PORT_RST:
    assert property (SYS_RST_O |=> PORT_OUT_O == 32'hFFFFFFFF) else $error("ports not high");
  AST_RST_LEN:
    assert property ($rose(SYS_RST_O) |-> SYS_RST_O [*8]) else $error("reset shorter than 8 clocks");
  AST_T2_KEEP:
    assert property (IRQ_REQ_O[5] && !apb_wr && !SYS_RST_O |=> IRQ_REQ_O[5] || SYS_RST_O)
      else $error("timer 2 request dropped");
  AST_T0_ACK:
    assert property (IRQ_ACK_I && IRQ_ACK_ID_I == 4'h1 && !TMR0_OVF_I && !apb_wr |=> !IRQ_REQ_O[1])
      else $error("timer 0 flag not cleared");
  AST_T0_SRC:
    assert property ($rose(IRQ_REQ_O[1]) |-> $past(TMR0_OVF_I) || $past(apb_wr))
      else $error("timer 0 request without cause");
  AST_GLOBAL:
    assert property (apb_wr && PADDR_I == 8'h04 && !PWDATA_I[7] |=> IRQ_REQ_O == 11'h000)
      else $error("request while globally disabled");
endmodule : rsif_monitor

bind rsif_top rsif_monitor #(.WD_BASE_BITS(WD_BASE_BITS)) rsif_monitor_i (
  .MCLK_I(MCLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
  .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .IRQ_ACK_I(IRQ_ACK_I), .IRQ_ACK_ID_I(IRQ_ACK_ID_I),
  .TMR0_OVF_I(TMR0_OVF_I), .CORE_PC_I(CORE_PC_I), .SYS_RST_O(SYS_RST_O), .PC_O(PC_O),
  .STACK_PTR_O(STACK_PTR_O), .PORT_OUT_O(PORT_OUT_O), .IRQ_REQ_O(IRQ_REQ_O));

// ===== test/rsif_tb_top.sv
`timescale 1ns/1ps
module rsif_tb_top;
  import rsif_pkg::*;
  // ************************************************
  // stimulus and design
  // ************************************************
  logic        MCLK_I, RST_I, PSEL_I, PENABLE_I, PWRITE_I, EXT_RST_I, IRQ_ACK_I, SERIAL_IRQ_I;
  logic        EXT_IRQ0_PIN_I, EXT_IRQ1_PIN_I, TMR0_OVF_I, TMR1_OVF_I, TMR2_OVF_I, TMR2_CAPRLD_I;
  logic [7:0]  PADDR_I;
  logic [31:0] PWDATA_I, PRDATA_O, PORT_OUT_O, rd;
  logic [3:0]  AUX_IRQ_I, IRQ_ACK_ID_I;
  logic [15:0] CORE_PC_I, PC_O;
  logic [7:0]  STACK_PTR_O;
  logic [10:0] IRQ_REQ_O;
  logic        PREADY_O, PSLVERR_O, SYS_RST_O, err;
  logic [31:0] mdl[7];
  logic [31:0] msk[7] = '{32'h7E, 32'hBF, 32'h1F, 32'hAF, 32'hC0, 32'hFF, 32'hFFFFFFFF};
  int          miscompares, checks, n;

  // short watchdog interval keeps the run brief
  rsif_top #(.WD_BASE_BITS(4)) rsif_top_i (
    .MCLK_I(MCLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
    .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .EXT_RST_I(EXT_RST_I), .EXT_IRQ0_PIN_I(EXT_IRQ0_PIN_I),
    .EXT_IRQ1_PIN_I(EXT_IRQ1_PIN_I), .TMR0_OVF_I(TMR0_OVF_I), .TMR1_OVF_I(TMR1_OVF_I),
    .TMR2_OVF_I(TMR2_OVF_I), .TMR2_CAPRLD_I(TMR2_CAPRLD_I), .SERIAL_IRQ_I(SERIAL_IRQ_I),
    .AUX_IRQ_I(AUX_IRQ_I), .IRQ_ACK_I(IRQ_ACK_I), .IRQ_ACK_ID_I(IRQ_ACK_ID_I), .CORE_PC_I(CORE_PC_I),
    .SYS_RST_O(SYS_RST_O), .PC_O(PC_O), .STACK_PTR_O(STACK_PTR_O), .PORT_OUT_O(PORT_OUT_O),
    .IRQ_REQ_O(IRQ_REQ_O));

  initial
  begin
    MCLK_I = 1'b0;
    forever #2 MCLK_I = ~MCLK_I;
  end

  always @(posedge MCLK_I) CORE_PC_I <= 16'($urandom);

  // ************************************************
  // bench tasks
  // ************************************************
  task step;
    @(posedge MCLK_I);
  endtask : step

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task mdl_rst(input logic [7:0] wdc);
    mdl = '{32'(wdc), 32'h0, 32'h0, 32'h0, 32'h0, 32'h07, 32'hFFFFFFFF};
  endtask : mdl_rst

  // setup then access; waits for pready, then releases
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    PSEL_I <= 1'b1;
    PENABLE_I <= 1'b0;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= d;
    step;
    PENABLE_I <= 1'b1;
    k = 0;
    step;
    while (PREADY_O !== 1'b1 && k < 50)
    begin
      k++;
      step;
    end
    if (k >= 50) miscompares++;
    rd = PRDATA_O;
    err = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
    if (w && a < 8'h1C) mdl[a[4:2]] = d & msk[a[4:2]];
    step;
  endtask : apb

  task rdc(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    chk("register", mdl[a[4:2]], rd);
  endtask : rdc

  task ack(input logic [3:0] id);
    IRQ_ACK_I <= 1'b1;
    IRQ_ACK_ID_I <= id;
    step;
    IRQ_ACK_I <= 1'b0;
    step;
  endtask : ack

  task end_of_test;
    $display("miscompares=%0d checks=%0d", miscompares, checks);
    if (miscompares == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  initial
  begin
    repeat (20000) step;
    miscompares++;
    end_of_test;
  end

  // ************************************************
  // scenarios
  // ************************************************
  initial
  begin
    {PSEL_I, PENABLE_I, PWRITE_I, EXT_RST_I, IRQ_ACK_I, SERIAL_IRQ_I} = '0;
    {TMR0_OVF_I, TMR1_OVF_I, TMR2_OVF_I, TMR2_CAPRLD_I, PADDR_I, PWDATA_I} = '0;
    {EXT_IRQ1_PIN_I, EXT_IRQ0_PIN_I} = 2'b11;
    {AUX_IRQ_I, IRQ_ACK_ID_I} = '0;
    RST_I = 1'b1;
    void'($urandom(45215));
    repeat (16) step;
    RST_I <= 1'b0;
    mdl_rst(8'h40);
    step;
    for (int i = 0; i < 7; i++) rdc(8'(4 * i));
    chk("stack_pins", mdl[5], 32'(STACK_PTR_O));
    chk("port_pins", mdl[6], PORT_OUT_O);
    apb(1'b1, 8'h1C, 32'hFF);
    chk("unmapped", 32'h1, 32'(err));
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, 8'h14 + 8'(4 * (i % 2)), $urandom);
      rdc(8'h14 + 8'(4 * (i % 2)));
    end
    // every source raised at once, then masked globally
    apb(1'b1, 8'h04, 32'hBF);
    apb(1'b1, 8'h08, 32'h1F);
    SERIAL_IRQ_I <= 1'b1;
    AUX_IRQ_I <= 4'hF;
    apb(1'b1, 8'h0C, 32'hAF);
    apb(1'b1, 8'h10, 32'hC0);
    apb(1'b1, 8'h00, 32'h08);
    chk("irq_all", 32'h7FF, 32'(IRQ_REQ_O));
    apb(1'b1, 8'h04, 32'h3F);
    chk("irq_global", 32'h0, 32'(IRQ_REQ_O));
    apb(1'b1, 8'h04, 32'hBF);
    apb(1'b1, 8'h08, 32'h0F);
    SERIAL_IRQ_I <= 1'b0;
    AUX_IRQ_I <= 4'h0;
    apb(1'b1, 8'h0C, 32'h0);
    apb(1'b1, 8'h10, 32'h0);
    chk("irq_clear", 32'h0, 32'(IRQ_REQ_O[9:0]));
    for (int i = 0; i < 2; i++)
    begin
      {TMR1_OVF_I, TMR0_OVF_I} <= 2'b01 << i;
      step;
      {TMR1_OVF_I, TMR0_OVF_I} <= 2'b00;
      step;
      chk("timer_set", 32'h1, 32'(IRQ_REQ_O[1 + 2 * i]));
      ack(4'(1 + 2 * i));
      chk("timer_ack", 32'h0, 32'(IRQ_REQ_O[1 + 2 * i]));
      {TMR2_CAPRLD_I, TMR2_OVF_I} <= 2'b01 << i;
      step;
      {TMR2_CAPRLD_I, TMR2_OVF_I} <= 2'b00;
      step;
      ack(4'h5);
      chk("timer2_keep", 32'h1, 32'(IRQ_REQ_O[5]));
      apb(1'b1, 8'h10, 32'h0);
    end
    // edge mode on both pins, then level mode on pin 0
    apb(1'b1, 8'h0C, 32'h05);
    for (int i = 0; i < 2; i++)
    begin
      {EXT_IRQ1_PIN_I, EXT_IRQ0_PIN_I} <= ~(2'b01 << i);
      repeat (12) step;
      chk("edge_set", 32'h1, 32'(IRQ_REQ_O[2 * i]));
      {EXT_IRQ1_PIN_I, EXT_IRQ0_PIN_I} <= 2'b11;
      ack(4'(2 * i));
      chk("edge_ack", 32'h0, 32'(IRQ_REQ_O[2 * i]));
    end
    apb(1'b1, 8'h0C, 32'h0);
    EXT_IRQ0_PIN_I <= 1'b0;
    repeat (12) step;
    ack(4'h0);
    chk("level_ack", 32'h1, 32'(IRQ_REQ_O[0]));
    // second ack two clocks on, so one ack misses a sampling strobe
    ack(4'h0);
    chk("level_ack2", 32'h1, 32'(IRQ_REQ_O[0]));
    EXT_IRQ0_PIN_I <= 1'b1;
    repeat (8) step;
    apb(1'b1, 8'h0C, 32'h0);
    // external reset keeps selection bit 4 but clears bit 5, sets no power-on flag
    // restart the count so no time-out lands before the read
    apb(1'b1, 8'h00, 32'h11);
    EXT_RST_I <= 1'b1;
    repeat (8) step;
    EXT_RST_I <= 1'b0;
    n = 0;
    while (SYS_RST_O !== 1'b0 && n < 100)
    begin
      n++;
      step;
    end
    mdl_rst(8'h10);
    rdc(8'h00);
    // periodic clears hold off the time-out
    apb(1'b1, 8'h04, 32'h80);
    apb(1'b1, 8'h08, 32'h10);
    repeat (6)
    begin
      apb(1'b1, 8'h00, 32'h01);
      repeat (7) step;
    end
    chk("wd_cleared", 32'h0, 32'(IRQ_REQ_O[10]));
    apb(1'b1, 8'h00, 32'h03);
    n = 0;
    while (IRQ_REQ_O[10] !== 1'b1 && n < 100)
    begin
      n++;
      step;
    end
    chk("wd_timeout", 32'h1, 32'(n < 100));
    n = 0;
    while (SYS_RST_O !== 1'b1 && n < 600)
    begin
      n++;
      step;
    end
    chk("wd_delay", 32'd512, 32'(n));
    n = 0;
    while (SYS_RST_O !== 1'b0 && n < 20)
    begin
      n++;
      step;
    end
    chk("wd_hold", 32'd8, 32'(n));
    mdl_rst(8'h06);
    for (int i = 0; i < 7; i++) rdc(8'(4 * i));
    apb(1'b1, 8'h00, 32'h0);
    end_of_test;
  end
endmodule : rsif_tb_top
